// ==== core/crps_channel_config.sv ====
// What this block does
// RULE1: Mapping resets to 1110,0100, each logical channel on its own number.
// RULE2: Two-bit field per logical channel; value k picks physical channel k+1.
// RULE3: Mapping write with duplicate physical codes is dropped whole.
// RULE4: Channel reset command leaves the mapping untouched.
// RULE5: Reset pin keeps mapping; only power-on restores the default.
// RULE6: Host wires only channels 1+2 and 3+4 as four-pair ports.
// RULE7: Host should run detection and classification after remapping.
// RULE8: Pair A priority byte: ch2 in 6:4, ch1 in 2:0, resets zero.
// RULE9: Pair B priority byte: ch4 in 6:4, ch3 in 2:0, resets zero.
// RULE10: Priorities act only while multibit priority select is set.
// RULE11: Each channel's priority decides its shutdown on a received code.
// RULE12: A code meeting a channel's priority removes that channel's power.
// RULE13: Priority shutdown clears the same state bits as a reset command.
// RULE14: Priority shutdown never cancels a running fault cool-down timer.
// RULE15: Mapping moves channels only inside their group of four.
// RULE16: Mapping write ignored unless all group channels are off.
// RULE17: Code above a channel's priority leaves it alone; 111 takes any.
`timescale 1ns/1ps
`default_nettype none
module crps_channel_config #(
    parameter int BIT_CYC = crps_pkg::SDN_BIT_CYC
) (
    // Clock and resets
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    input wire logic i_porn,
    // Command port from the serial front end
    input wire crps_pkg::crps_req_t i_req,
    output logic [7:0] o_rdata,
    // Channel status and mode select
    input wire logic [crps_pkg::NCH-1:0] i_chan_off,
    input wire logic i_multibit_priority_select,
    // Fast shutdown pin
    input wire logic i_serial_shutdown_input,
    // Mapping and per physical channel actions
    output logic [7:0] o_map,
    output logic [crps_pkg::NCH-1:0] o_power_off,
    output logic [crps_pkg::NCH-1:0] o_state_clear,
    output logic [crps_pkg::NCH-1:0] o_cooldown_cancel
);
    localparam int CW = $clog2(BIT_CYC + 1);
    localparam logic [CW-1:0] FULL_M1 = CW'(BIT_CYC - 1);
    localparam logic [CW-1:0] HALF_M1 = CW'((BIT_CYC / 2) - 1);
    localparam logic [1:0] LAST_BIT = 2'(crps_pkg::SDN_BITS - 1);

    // ---------------------------------------------------------------
    // Decoding helpers
    // ---------------------------------------------------------------
    function automatic logic map_has_dup(input logic [7:0] m);
        logic dup;
        dup = 1'b0;
        for (int i = 0; i < crps_pkg::NCH; i++) begin
            for (int j = i + 1; j < crps_pkg::NCH; j++) begin
                if (m[i*crps_pkg::MAPW +: crps_pkg::MAPW] ==
                    m[j*crps_pkg::MAPW +: crps_pkg::MAPW]) begin
                    dup = 1'b1;
                end
            end
        end
        return dup;
    endfunction

    // Logical vector to physical vector through the map
    function automatic logic [crps_pkg::NCH-1:0] to_phys(
        input logic [crps_pkg::NCH-1:0] lv, input logic [7:0] m);
        logic [crps_pkg::NCH-1:0] pv;
        pv = '0;
        for (int n = 0; n < crps_pkg::NCH; n++) begin
            if (lv[n]) begin
                pv[m[n*crps_pkg::MAPW +: crps_pkg::MAPW]] = 1'b1;
            end
        end
        return pv;
    endfunction

    // ---------------------------------------------------------------
    // Register decode
    // ---------------------------------------------------------------
    crps_pkg::crps_prio_pair_t prio_a_q, prio_b_q;
    logic [7:0] map_q;
    wire wr_remap = i_req.wr && (i_req.cmd == crps_pkg::CMD_REMAP);
    wire wr_prio_a = i_req.wr && (i_req.cmd == crps_pkg::CMD_PRIO_A);
    wire wr_prio_b = i_req.wr && (i_req.cmd == crps_pkg::CMD_PRIO_B);
    wire wr_ch_rst = i_req.wr && (i_req.cmd == crps_pkg::CMD_CH_RESET);
    wire group_off = &i_chan_off;
    wire map_dup = map_has_dup(i_req.data);
    wire map_take = wr_remap && group_off && !map_dup; // RULE3 RULE16

    // Mapping sits on power-on reset only, so the reset pin spares it
    always_ff @(posedge i_sys_clk or negedge i_porn) begin
        if (!i_porn) begin
            map_q <= crps_pkg::REMAP_RST; // RULE1 RULE5
        end else if (map_take) begin
            map_q <= i_req.data; // RULE2 RULE15
        end
    end
    assign o_map = map_q;

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            prio_a_q <= crps_pkg::PRIO_RST; // RULE8
            prio_b_q <= crps_pkg::PRIO_RST; // RULE9
        end else begin
            if (wr_prio_a) begin
                prio_a_q <= i_req.data & crps_pkg::PRIO_MASK; // RULE8
            end
            if (wr_prio_b) begin
                prio_b_q <= i_req.data & crps_pkg::PRIO_MASK; // RULE9
            end
        end
    end

    // ---------------------------------------------------------------
    // Read back
    // ---------------------------------------------------------------
    logic [7:0] rd_sel;
    assign rd_sel = (i_req.cmd == crps_pkg::CMD_REMAP) ? map_q :
                    (i_req.cmd == crps_pkg::CMD_PRIO_A) ? prio_a_q :
                    (i_req.cmd == crps_pkg::CMD_PRIO_B) ? prio_b_q :
                    crps_pkg::RD_ZERO;

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_rdata <= crps_pkg::RD_ZERO;
        end else if (i_req.rd) begin
            o_rdata <= rd_sel;
        end
    end

    // ---------------------------------------------------------------
    // Shutdown pin synchroniser and receiver
    // ---------------------------------------------------------------
    // Frame: high start bit, then three code bits, most significant first
    logic sync1_q, sync2_q;
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
        end else begin
            sync1_q <= i_serial_shutdown_input;
            sync2_q <= sync1_q;
        end
    end

    crps_pkg::crps_rx_state_t rx_q, rx_d;
    logic [CW-1:0] tick_q, tick_d;
    logic [1:0] nbit_q, nbit_d;
    logic [2:0] shift_q, shift_d;
    logic code_vld_d;
    wire tick_zero = (tick_q == '0);

    always_comb begin
        rx_d = rx_q;
        tick_d = tick_zero ? tick_q : tick_q - 1'b1;
        nbit_d = nbit_q;
        shift_d = shift_q;
        code_vld_d = 1'b0;
        case (rx_q)
            crps_pkg::RX_IDLE: begin
                if (sync2_q) begin
                    rx_d = crps_pkg::RX_START;
                    tick_d = HALF_M1;
                end
            end
            crps_pkg::RX_START: begin
                // Mid-bit recheck rejects short glitches on the pin
                if (tick_zero) begin
                    rx_d = sync2_q ? crps_pkg::RX_DATA : crps_pkg::RX_IDLE;
                    tick_d = FULL_M1;
                    nbit_d = 2'h0;
                end
            end
            crps_pkg::RX_DATA: begin
                if (tick_zero) begin
                    shift_d = {shift_q[1:0], sync2_q};
                    tick_d = FULL_M1;
                    nbit_d = nbit_q + 2'h1;
                    if (nbit_q == LAST_BIT) begin
                        code_vld_d = 1'b1;
                        rx_d = crps_pkg::RX_IDLE;
                    end
                end
            end
            default: begin
                rx_d = crps_pkg::RX_IDLE;
            end
        endcase
    end

    logic code_vld_q;
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rx_q <= crps_pkg::RX_IDLE;
            tick_q <= '0;
            nbit_q <= 2'h0;
            shift_q <= 3'h0;
            code_vld_q <= 1'b0;
        end else begin
            rx_q <= rx_d;
            tick_q <= tick_d;
            nbit_q <= nbit_d;
            shift_q <= shift_d;
            code_vld_q <= code_vld_d;
        end
    end

    // ---------------------------------------------------------------
    // Priority compare
    // ---------------------------------------------------------------
    logic [crps_pkg::NCH-1:0][2:0] prio;
    assign prio = {prio_b_q.upper, prio_b_q.lower,
                   prio_a_q.upper, prio_a_q.lower};

    logic [crps_pkg::NCH-1:0] hit_log;
    genvar g;
    generate
        for (g = 0; g < crps_pkg::NCH; g++) begin : g_cmp
            // Larger code spares the channel; 111 answers to any code
            assign hit_log[g] = code_vld_q && i_multibit_priority_select &&
                                (shift_q <= prio[g]); // RULE10 RULE11 RULE17
        end
    endgenerate

    wire [crps_pkg::NCH-1:0] rst_log = wr_ch_rst ?
        i_req.data[crps_pkg::NCH-1:0] : '0;
    wire [crps_pkg::NCH-1:0] hit_phys = to_phys(hit_log, map_q);
    wire [crps_pkg::NCH-1:0] rst_phys = to_phys(rst_log, map_q);

    // ---------------------------------------------------------------
    // Channel actions
    // ---------------------------------------------------------------
    // Shutdown leaves cool-down alone; only the reset command cancels it
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_power_off <= '0;
            o_state_clear <= '0;
            o_cooldown_cancel <= '0;
        end else begin
            o_power_off <= hit_phys; // RULE12
            o_state_clear <= hit_phys | rst_phys; // RULE13
            o_cooldown_cancel <= rst_phys; // RULE14 RULE4
        end
    end

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rstn || !i_porn);

    wire [crps_pkg::NCH-1:0] p7_log;
    generate
        for (g = 0; g < crps_pkg::NCH; g++) begin : g_p7
            assign p7_log[g] = (prio[g] == crps_pkg::PRIO_LOWEST);
        end
    endgenerate
    wire [crps_pkg::NCH-1:0] p7_phys = to_phys(p7_log, map_q);

    chk_map_dup_drop: assert property (wr_remap && map_dup |=> // RULE3
        $stable(o_map)) else $error("duplicate map write changed map");
    chk_map_busy_drop: assert property (wr_remap && !group_off |=> // RULE16
        $stable(o_map)) else $error("map changed while channel on");
    chk_map_accept: assert property (map_take |=> // RULE2
        o_map == $past(i_req.data)) else $error("valid map write lost");
    chk_chrst_keeps_map: assert property (wr_ch_rst && !wr_remap |=> // RULE4
        $stable(o_map)) else $error("reset command changed map");
    chk_prio_a_write: assert property (wr_prio_a |=> // RULE8
        prio_a_q == ($past(i_req.data) & crps_pkg::PRIO_MASK))
        else $error("pair a priority write wrong");
    chk_prio_b_write: assert property (wr_prio_b |=> // RULE9
        prio_b_q == ($past(i_req.data) & crps_pkg::PRIO_MASK))
        else $error("pair b priority write wrong");
    chk_select_gates: assert property (!i_multibit_priority_select // RULE10
        ##1 !i_multibit_priority_select |=> o_power_off == '0)
        else $error("shutdown without multibit select");
    chk_top_code_all: assert property (code_vld_q && // RULE11
        i_multibit_priority_select && shift_q == 3'h0 |=> &o_power_off)
        else $error("code 000 missed a channel");
    chk_low_code_few: assert property (code_vld_q && // RULE17
        i_multibit_priority_select && shift_q == crps_pkg::PRIO_LOWEST |=>
        o_power_off == $past(p7_phys))
        else $error("code 111 hit a higher priority channel");
    chk_clear_follows: assert property ((o_power_off & ~o_state_clear) // RULE13
        == '0) else $error("shutdown without state clear");
    chk_cooldown_kept: assert property (!$past(wr_ch_rst) |-> // RULE14
        o_cooldown_cancel == '0) else $error("cool-down cancelled");
    chk_por_default: assert property ($rose(i_porn) |-> // RULE1
        o_map == crps_pkg::REMAP_RST) else $error("map default lost");
    // Map would already sit at its default here if the pin reset it
    chk_pin_keeps_map: assert property (disable iff (!i_porn) // RULE5
        $fell(i_rstn) |-> $stable(o_map))
        else $error("reset pin changed map");
    chk_chrst_clears: assert property (wr_ch_rst && // RULE13
        i_req.data[crps_pkg::NCH-1:0] != '0 |=>
        $countones(o_cooldown_cancel) ==
        $countones($past(i_req.data[crps_pkg::NCH-1:0])) &&
        (o_cooldown_cancel & ~o_state_clear) == '0)
        else $error("reset command missed a channel");
    chk_prio_read_spare: assert property (i_req.rd && // RULE8
        i_req.cmd == crps_pkg::CMD_PRIO_A |=>
        (o_rdata & ~crps_pkg::PRIO_MASK) == crps_pkg::RD_ZERO)
        else $error("pair a spare bits read high");
endmodule // crps_channel_config
`default_nettype wire

// ==== core/crps_pkg.sv ====
package crps_pkg;
    // ---------------------------------------------------------------
    // Command codes
    // ---------------------------------------------------------------
    localparam logic [7:0] CMD_CH_RESET = 8'h1a;
    localparam logic [7:0] CMD_REMAP = 8'h26;
    localparam logic [7:0] CMD_PRIO_A = 8'h27;
    localparam logic [7:0] CMD_PRIO_B = 8'h28;
    // ---------------------------------------------------------------
    // Layout and reset values
    // ---------------------------------------------------------------
    localparam int NCH = 4;
    localparam int MAPW = 2;
    localparam int PRIO_W = 3;
    localparam logic [7:0] REMAP_RST = 8'he4;
    localparam logic [7:0] PRIO_RST = 8'h00;
    localparam logic [7:0] PRIO_MASK = 8'h77;
    localparam logic [2:0] PRIO_LOWEST = 3'h7;
    localparam logic [7:0] RD_ZERO = 8'h00;
    // ---------------------------------------------------------------
    // Serial shutdown timing
    // ---------------------------------------------------------------
    localparam int CLK_HZ = 25_000_000;
    localparam int SDN_BIT_NS = 1000;
    localparam int SDN_BIT_CYC = (SDN_BIT_NS * (CLK_HZ / 1_000_000)) / 1000;
    localparam int SDN_BITS = 3;
    // ---------------------------------------------------------------
    // Types
    // ---------------------------------------------------------------
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] cmd;
        logic [7:0] data;
    } crps_req_t;
    typedef struct packed {
        logic spare_hi;
        logic [2:0] upper;
        logic spare_lo;
        logic [2:0] lower;
    } crps_prio_pair_t;
    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_START = 2'b01,
        RX_DATA = 2'b10
    } crps_rx_state_t;
endpackage

// ==== bench/crps_oss_tx.sv ====
`timescale 1ns/1ps
`default_nettype none
module crps_sdn_tx #(
    parameter int BIT_CYC = 4
) (
    // Clock
    input wire logic i_sys_clk,
    // Shutdown line into the device
    output var logic o_line
);
    // ------------------------------------------------------------------
    // Frame sender
    // ------------------------------------------------------------------
    // Idle low, so every frame opens with a clean rising start edge
    initial o_line = 1'b0;

    task automatic send(input logic [2:0] code);
        @(posedge i_sys_clk);
        #1 o_line = 1'b1;
        repeat (BIT_CYC) @(posedge i_sys_clk);
        for (int b = 2; b >= 0; b--) begin
            #1 o_line = code[b];
            repeat (BIT_CYC) @(posedge i_sys_clk);
        end
        #1 o_line = 1'b0;
    endtask
endmodule // crps_sdn_tx
`default_nettype wire

// ==== bench/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam int BC = 4;
    logic i_sys_clk, i_rstn, i_porn, sel, clr;
    crps_pkg::crps_req_t req;
    logic [3:0] off, po, sc, cc, po_s, sc_s, cc_s;
    logic [7:0] rdata, map;
    wire logic sdn_line;
    int err_total, n_compared;

    crps_channel_config #(.BIT_CYC(BC)) crps_channel_config_i (
        .i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_porn(i_porn),
        .i_req(req), .o_rdata(rdata), .i_chan_off(off),
        .i_multibit_priority_select(sel),
        .i_serial_shutdown_input(sdn_line), .o_map(map), .o_power_off(po),
        .o_state_clear(sc), .o_cooldown_cancel(cc));
    crps_sdn_tx #(.BIT_CYC(BC)) crps_sdn_tx_i (
        .i_sys_clk(i_sys_clk), .o_line(sdn_line));

    // ------------------------------------------------------------------
    // Sticky capture of one-cycle action pulses
    // ------------------------------------------------------------------
    always @(posedge i_sys_clk) begin
        if (clr) begin
            po_s <= '0;
            sc_s <= '0;
            cc_s <= '0;
        end else begin
            po_s <= po_s | po;
            sc_s <= sc_s | sc;
            cc_s <= cc_s | cc;
        end
    end

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge i_sys_clk);
        #1;
    endtask

    // Gap cycle after each request keeps one assignment per time step
    task automatic wr(input logic [7:0] c, input logic [7:0] d);
        req = {1'b1, 1'b0, c, d};
        @(posedge i_sys_clk);
        #1 req = '0;
        cyc(1);
    endtask

    task automatic rd(input logic [7:0] c, input logic [7:0] exp);
        req = {1'b0, 1'b1, c, 8'h00};
        @(posedge i_sys_clk);
        #1 req = '0;
        cyc(1);
        chk(rdata, exp);
    endtask

    // Physical channels hit by a code; pr holds pair B then pair A
    function automatic logic [3:0] fire(input logic [2:0] code,
        input logic [7:0] m, input logic [15:0] pr);
        logic [3:0] f;
        f = '0;
        for (int n = 0; n < 4; n++) begin
            if (code <= pr[8*(n/2) + 4*(n%2) +: 3]) f[m[2*n +: 2]] = 1'b1;
        end
        return f;
    endfunction

    task automatic clear_caps();
        clr = 1'b1;
        cyc(1);
        clr = 1'b0;
    endtask

    task automatic frame(input logic [2:0] code, input logic [3:0] exp);
        clear_caps();
        crps_sdn_tx_i.send(code);
        cyc(4 * BC);
        chk({4'h0, po_s}, {4'h0, exp});
        chk({4'h0, sc_s}, {4'h0, exp});
        chk({4'h0, cc_s}, 8'h00);
    endtask

    task automatic end_sim();
        $display("compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Clock, watchdog, tests
    // ------------------------------------------------------------------
    initial begin
        i_sys_clk = 1'b0;
        forever #20 i_sys_clk = ~i_sys_clk;
    end

    // Tests need well under a thousand cycles
    initial begin
        #(20_000 * 40);
        err_total++;
        end_sim();
    end

    initial begin
        i_rstn = 1'b0;
        i_porn = 1'b0;
        req = '0;
        off = 4'hf;
        sel = 1'b1;
        clr = 1'b1;
        err_total = 0;
        n_compared = 0;
        repeat (20) @(posedge i_sys_clk);
        #1 i_rstn = 1'b1;
        i_porn = 1'b1;
        cyc(1);
        chk(map, 8'he4);
        rd(crps_pkg::CMD_PRIO_A, 8'h00);
        rd(crps_pkg::CMD_PRIO_B, 8'h00);
        $display("test reset_values done");
        wr(crps_pkg::CMD_PRIO_A, 8'hff);
        rd(crps_pkg::CMD_PRIO_A, 8'h77);
        wr(crps_pkg::CMD_PRIO_B, 8'hda);
        rd(crps_pkg::CMD_PRIO_B, 8'h52);
        rd(8'h30, 8'h00);
        $display("test priority_bytes done");
        // Reversal keeps logical 1+2 and 3+4 side by side
        wr(crps_pkg::CMD_REMAP, 8'h1b);
        chk(map, 8'h1b);
        rd(crps_pkg::CMD_REMAP, 8'h1b);
        wr(crps_pkg::CMD_REMAP, 8'he5);
        chk(map, 8'h1b);
        off = 4'hb;
        wr(crps_pkg::CMD_REMAP, 8'he4);
        chk(map, 8'h1b);
        // Whole group set back off after the refused remap; no power-on is requested
        off = 4'hf;
        $display("test remap done");
        clear_caps();
        wr(crps_pkg::CMD_CH_RESET, 8'h01);
        cyc(2);
        chk({4'h0, sc_s}, 8'h08);
        chk({4'h0, cc_s}, 8'h08);
        chk(map, 8'h1b);
        $display("test reset_command done");
        wr(crps_pkg::CMD_PRIO_A, 8'h70);
        wr(crps_pkg::CMD_PRIO_B, 8'h43);
        for (int c = 0; c < 8; c++) begin
            frame(3'(c), fire(3'(c), 8'h1b, 16'h4370));
        end
        sel = 1'b0;
        frame(3'h0, 4'h0);
        $display("test shutdown_codes done");
        i_rstn = 1'b0;
        cyc(2);
        i_rstn = 1'b1;
        cyc(1);
        chk(map, 8'h1b);
        rd(crps_pkg::CMD_PRIO_A, 8'h00);
        rd(crps_pkg::CMD_PRIO_B, 8'h00);
        i_porn = 1'b0;
        cyc(2);
        i_porn = 1'b1;
        cyc(1);
        chk(map, 8'he4);
        $display("test reset_pins done");
        end_sim();
    end
endmodule // tb_top
`default_nettype wire
